// ==== bench/spfc_host.sv ====
// host model on the serial line: decodes port frames, sends frames in
// assumes both ends use the same bit period, counted in pclk cycles
`timescale 1ns/1ps
module spfc_host #(
  parameter int BIT = 352
) (
  // clock
  input wire logic pclk,
  // serial lines, named from the port side
  input wire logic port_txd,
  output logic port_rxd
);
  logic [9:0] got[$];
  logic [9:0] frm;

  // line idles at mark
  initial port_rxd = 1'b1;

  // one frame per falling edge, each bit sampled mid-way
  initial
  begin
    forever
    begin
      @(negedge port_txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 10; i++)
      begin
        frm[i] = port_txd;
        if (i < 9)
          repeat (BIT) @(posedge pclk);
      end
      got.push_back(frm);
    end
  end

  // start, eight bits lsb first, one stop, same settings as the port
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      port_rxd <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask : send
endmodule : spfc_host

// ==== bench/spfc_uart_tb.sv ====
// testbench for the serial port: apb master, host model, handshake lines
// assumes the port runs at baud select 7 (22 pclk per tick, 16 ticks a bit)
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_uart_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic txd;
  logic rxd;
  logic cts = 1'b0;
  logic dsr = 1'b0;
  logic rts;
  logic dtr;
  int err_total = 0;
  int samples_checked = 0;

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  spfc_uart dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr), .rts(rts), .dtr(dtr)
  );

  spfc_host #(.BIT(16 * 22)) host_u (.pclk(pclk), .port_txd(txd), .port_rxd(rxd));

  // word compare
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // single line compare
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask : chkb

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chkb("write error", 1'b0, e);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(what, exp, q);
    chkb(what, ee, e);
  endtask : rd_chk

  // control word at 115200 baud
  function automatic logic [31:0] ctrl(input logic [2:0] fl, input logic [1:0] f,
                                       input logic s);
    return {23'h00_0000, s, fl, f, 3'h7};
  endfunction : ctrl

  // wait for one frame from the port and compare it whole
  task automatic take(input string what, input logic [7:0] c);
    logic [9:0] f;
    int n;
    n = 0;
    f = 10'h000;
    while (host_u.got.size() == 0 && n < 8000)
    begin
      @(posedge pclk);
      n++;
    end
    if (host_u.got.size() > 0)
      f = host_u.got.pop_front();
    chk(what, {22'h00_0000, 1'b1, c, 1'b0}, {22'h00_0000, f});
  endtask : take

  // longer than one frame with no start seen
  task automatic quiet(input string what);
    repeat (4000) @(posedge pclk);
    chk(what, 32'h0000_0000, host_u.got.size());
  endtask : quiet

  task automatic t_reset();
    @(posedge pclk);
    chkb("txd idle", 1'b1, txd);
    chkb("rts reset", 1'b0, rts);
    chkb("dtr reset", 1'b0, dtr);
    rd_chk("ctrl reset", `SPFC_OFF_CTRL, 32'h0000_0026, 1'b0);
    rd_chk("unmapped", 8'h10, 32'h0000_0000, 1'b1);
    rd_chk("txdata read", `SPFC_OFF_TXD, 32'h0000_0000, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_none();
    wr(`SPFC_OFF_CTRL, ctrl(spfc_pkg::SPFC_FLOW_NONE, `SPFC_FMT_8N, 1'b1));
    host_u.send(8'h13);
    repeat (8) @(posedge pclk);
    rd_chk("stop char kept", `SPFC_OFF_RXD, 32'h0000_0113, 1'b0);
    rd_chk("rx empty", `SPFC_OFF_RXD, 32'h0000_0013, 1'b0);
    wr(`SPFC_OFF_TXD, 32'h0000_00a5);
    take("8 bit frame", 8'ha5);
    chkb("rts none", 1'b0, rts);
    chkb("dtr none", 1'b0, dtr);
    $display("test none done");
  endtask : t_none

  task automatic t_fmt();
    logic p;
    for (int f = 1; f < 3; f++)
    begin
      p = (^8'h35) ^ (f == 2);
      wr(`SPFC_OFF_CTRL, ctrl(spfc_pkg::SPFC_FLOW_NONE, 2'(f), 1'b0));
      wr(`SPFC_OFF_TXD, 32'h0000_00b5);
      take("7 bit tx", {p, 7'h35});
      host_u.send({p, 7'h35});
      repeat (8) @(posedge pclk);
      rd_chk("7 bit rx", `SPFC_OFF_RXD, 32'h0000_0135, 1'b0);
      // bad parity is dropped and flagged, then cleared by writing one
      host_u.send({!p, 7'h35});
      repeat (8) @(posedge pclk);
      rd_chk("parity error", `SPFC_OFF_STAT, 32'h0000_0200, 1'b0);
      wr(`SPFC_OFF_STAT, 32'h0000_0200);
      rd_chk("parity cleared", `SPFC_OFF_STAT, 32'h0000_0000, 1'b0);
    end
    $display("test formats done");
  endtask : t_fmt

  task automatic t_xon();
    wr(`SPFC_OFF_CTRL, ctrl(spfc_pkg::SPFC_FLOW_XON, `SPFC_FMT_8N, 1'b0));
    host_u.send(`SPFC_XOFF);
    repeat (8) @(posedge pclk);
    rd_chk("xoff consumed", `SPFC_OFF_RXD, 32'h0000_0035, 1'b0);
    wr(`SPFC_OFF_TXD, 32'h0000_0041);
    quiet("halted");
    rd_chk("halt status", `SPFC_OFF_STAT, 32'h0000_0100, 1'b0);
    host_u.send(`SPFC_XON);
    take("resumed", 8'h41);
    $display("test xon done");
  endtask : t_xon

  task automatic t_gate();
    for (int m = 2; m < 5; m++)
    begin
      @(posedge pclk);
      cts <= 1'b0;
      dsr <= 1'b0;
      wr(`SPFC_OFF_CTRL, ctrl(3'(m), `SPFC_FMT_8N, 1'b1));
      repeat (4) @(posedge pclk);
      chkb("dtr level", m != 3, dtr);
      chkb("rts level", m != 2, rts);
      wr(`SPFC_OFF_TXD, 32'h0000_00c0 + m);
      @(posedge pclk);
      if (m == 2)
        cts <= 1'b1;
      else
        dsr <= 1'b1;
      quiet("gate shut");
      @(posedge pclk);
      cts <= 1'b1;
      dsr <= 1'b1;
      take("gate open", 8'(8'hc0 + m));
    end
    wr(`SPFC_OFF_CTRL, ctrl(spfc_pkg::SPFC_FLOW_MODEM, `SPFC_FMT_8N, 1'b0));
    repeat (4) @(posedge pclk);
    chkb("dtr deselected", 1'b0, dtr);
    chkb("rts modem", 1'b1, rts);
    $display("test gates done");
  endtask : t_gate

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // main sequence after 16 cycles of reset
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_none();
    t_fmt();
    t_xon();
    t_gate();
    conclude();
  end

  // watchdog well past the expected run length
  initial
  begin
    repeat (90000) @(posedge pclk);
    err_total++;
    $display("MISMATCH watchdog expected done seen timeout");
    conclude();
  end
endmodule : spfc_uart_tb

// ==== design/spfc_fifo.sv ====
// synchronous fifo with a registered output stage
// assumes one clock and power-of-two depth
`timescale 1ns/1ps
module spfc_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // words held, output stage included
  output logic [AW:0] level
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic push;
  logic load;

  // handshakes and counts
  assign in_ready = cnt != (AW+1)'(D);
  assign push = in_valid && in_ready;
  assign load = (cnt != '0) && (!out_valid || out_ready);
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(load);
  assign level = cnt + (AW+1)'(out_valid);

  // storage array
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

  // pointers and output register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      if (push)
        wptr <= wptr + AW'(1);
      if (load)
      begin
        out_data <= mem[rptr];
        rptr <= rptr + AW'(1);
      end
      out_valid <= load || (out_valid && !out_ready);
    end
  end
endmodule : spfc_fifo

// ==== design/spfc_map.svh ====
// register map, field positions, reset values and timing counts
// assumes a 40 MHz pclk and an APB slave with 8-bit byte addresses
`ifndef SPFC_MAP_SVH
`define SPFC_MAP_SVH
// system clock rate in Hz
`define SPFC_CLK_HZ 40000000
// oversampling ticks per bit
`define SPFC_OVS 16
// register byte offsets
`define SPFC_OFF_CTRL 8'h00
`define SPFC_OFF_STAT 8'h04
`define SPFC_OFF_TXD 8'h08
`define SPFC_OFF_RXD 8'h0C
// control fields
`define SPFC_F_BAUD 2:0
`define SPFC_F_FMT 4:3
`define SPFC_F_FLOW 7:5
`define SPFC_B_IFSEL 8
// control reset: 57600 baud, none/8 bits, xon/xoff, serial not selected
`define SPFC_CTRL_RST 9'h026
// frame codes
`define SPFC_FMT_8N 2'h0
`define SPFC_FMT_7E 2'h1
`define SPFC_FMT_7O 2'h2
// status write-one-to-clear bits
`define SPFC_B_PERR 9
`define SPFC_B_FERR 10
`define SPFC_B_OVR 11
// selectable baud rates in baud
`define SPFC_BAUD_0 1200
`define SPFC_BAUD_1 2400
`define SPFC_BAUD_2 4800
`define SPFC_BAUD_3 9600
`define SPFC_BAUD_4 19200
`define SPFC_BAUD_5 38400
`define SPFC_BAUD_6 57600
`define SPFC_BAUD_7 115200
// flow characters
`define SPFC_XOFF 8'h13
`define SPFC_XON 8'h11
// receive level that throttles the sender (100 characters)
`define SPFC_RX_HIGH 8'h64
`endif

// ==== design/spfc_pkg.sv ====
// types shared by the serial port and its testbench
// assumes nothing beyond the map header for numbers
package spfc_pkg;
  // flow control schemes
  typedef enum logic [2:0] {
    SPFC_FLOW_NONE = 3'h0,
    SPFC_FLOW_XON = 3'h1,
    SPFC_FLOW_DTR = 3'h2,
    SPFC_FLOW_RTS = 3'h3,
    SPFC_FLOW_MODEM = 3'h4
  } spfc_flow_e;
  // transmit engine states
  typedef enum logic {
    SPFC_TX_IDLE = 1'b0,
    SPFC_TX_SEND = 1'b1
  } spfc_txst_e;
  // receive engine states, gray along start, data, stop
  typedef enum logic [1:0] {
    SPFC_RX_IDLE = 2'b00,
    SPFC_RX_START = 2'b01,
    SPFC_RX_DATA = 2'b11,
    SPFC_RX_STOP = 2'b10
  } spfc_rxst_e;
endpackage : spfc_pkg

// ==== design/spfc_uart.sv ====
// serial port with selectable framing and flow control, apb registers
// assumes pclk at 40 MHz, rxd/cts/dsr synchronous to pclk, 1 = asserted
// Summary of operation
// - no flow: handshakes idle, no flow characters
// - xoff character 13h halts transmission
// - xon character 11h resumes pending transmission
// - dtr/dsr mode: send only while dsr
// - dtr/dsr mode: drop dtr near 100 characters
// - rts/cts mode: cts gates, rts throttles
// - modem mode: dtr true once interface selected
// - modem mode: rts drops near 100 characters
// - frame: start, 7+parity or 8, stop
// - exactly one start and one stop bit
// - eight baud rates, default 57600
// - formats: none/8, even/7, odd/7
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_uart (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line and handshakes
  output logic txd,
  input wire logic rxd,
  input wire logic cts,
  input wire logic dsr,
  output logic rts,
  output logic dtr
);
  logic [8:0] ctrl;
  logic perr;
  logic ferr;
  logic ovr;
  logic tx_halt;
  logic [11:0] div_cnt;
  logic tick;
  spfc_pkg::spfc_txst_e tx_st;
  spfc_pkg::spfc_txst_e next_tx_st;
  logic [9:0] tx_sh;
  logic [3:0] tx_sub;
  logic [3:0] tx_idx;
  spfc_pkg::spfc_rxst_e rx_st;
  logic [3:0] rx_sub;
  logic [2:0] rx_idx;
  logic [7:0] rx_sh;
  logic txf_iready;
  logic txf_ovalid;
  logic [7:0] txf_odata;
  logic rxf_iready;
  logic rxf_ovalid;
  logic [7:0] rxf_odata;
  logic [7:0] rxf_level;

  // baud divisor from rate select, rounded to nearest
  function automatic logic [11:0] spfc_div(input logic [2:0] sel);
    logic [31:0] b;
    begin
      case (sel)
        3'h0: b = `SPFC_BAUD_0;
        3'h1: b = `SPFC_BAUD_1;
        3'h2: b = `SPFC_BAUD_2;
        3'h3: b = `SPFC_BAUD_3;
        3'h4: b = `SPFC_BAUD_4;
        3'h5: b = `SPFC_BAUD_5;
        3'h6: b = `SPFC_BAUD_6;
        default: b = `SPFC_BAUD_7;
      endcase
      spfc_div = 12'((`SPFC_CLK_HZ + (`SPFC_OVS / 2) * b) / (`SPFC_OVS * b));
    end
  endfunction : spfc_div

  // parity over the seven data bits, even or odd
  function automatic logic spfc_par7(input logic [6:0] d, input logic odd);
    spfc_par7 = (^d) ^ odd;
  endfunction : spfc_par7

  // mode decode
  wire [2:0] flow_bits = ctrl[`SPFC_F_FLOW];
  wire m_none = flow_bits == spfc_pkg::SPFC_FLOW_NONE;
  wire m_xon = flow_bits == spfc_pkg::SPFC_FLOW_XON;
  wire m_dtr = flow_bits == spfc_pkg::SPFC_FLOW_DTR;
  wire m_rts = flow_bits == spfc_pkg::SPFC_FLOW_RTS;
  wire m_modem = flow_bits == spfc_pkg::SPFC_FLOW_MODEM;
  wire [1:0] fmt = ctrl[`SPFC_F_FMT];
  wire seven = (fmt == `SPFC_FMT_7E) || (fmt == `SPFC_FMT_7O);
  wire odd = fmt == `SPFC_FMT_7O;
  wire [11:0] div_top = spfc_div(ctrl[`SPFC_F_BAUD]) - 12'h001;

  // apb decode
  wire apb_acc = psel && penable;
  wire apb_done = apb_acc && pready;
  wire hit_ctrl = paddr == `SPFC_OFF_CTRL;
  wire hit_stat = paddr == `SPFC_OFF_STAT;
  wire hit_tx = paddr == `SPFC_OFF_TXD;
  wire hit_rx = paddr == `SPFC_OFF_RXD;
  wire wr_ctrl = apb_done && pwrite && hit_ctrl;
  wire wr_stat = apb_done && pwrite && hit_stat;
  wire wr_tx = apb_done && pwrite && hit_tx && txf_iready;
  wire rd_rx = apb_done && !pwrite && hit_rx;
  wire apb_err = !(hit_ctrl || hit_stat || hit_tx || hit_rx) ||
                 (hit_tx && pwrite && !txf_iready);
  wire [14:0] status = {tx_st == spfc_pkg::SPFC_TX_SEND, rxf_ovalid, !txf_iready,
                        ovr, ferr, perr, tx_halt, rxf_level};
  wire [31:0] rd_mux = hit_ctrl ? {23'h00_0000, ctrl} :
                       hit_stat ? {17'h0_0000, status} :
                       hit_rx ? {23'h00_0000, rxf_ovalid, rxf_odata} : 32'h0000_0000;

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_acc && !pready;
      if (apb_acc && !pready)
      begin
        pslverr <= apb_err;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `SPFC_CTRL_RST;
    else if (wr_ctrl)
      ctrl <= pwdata[8:0];
  end

  // oversampling tick, 16 per bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 12'h000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= div_cnt >= div_top;
      div_cnt <= (div_cnt >= div_top) ? 12'h000 : div_cnt + 12'h001;
    end
  end

  // transmit gating per flow scheme
  wire tx_allow = m_xon ? !tx_halt :
                  m_dtr ? dsr :
                  m_rts ? cts :
                  m_modem ? (cts && dsr) : 1'b1;
  wire tx_idle = tx_st == spfc_pkg::SPFC_TX_IDLE;
  wire tx_take = tx_idle && tx_allow && txf_ovalid;
  wire [6:0] td = txf_odata[6:0];
  wire tx_b7 = seven ? spfc_par7(td, odd) : txf_odata[7];
  wire [9:0] tx_frame = {1'b1, tx_b7, td, 1'b0};
  wire tx_bit_end = !tx_idle && tick && (tx_sub == 4'hF);
  wire tx_last = tx_bit_end && (tx_idx == 4'h9);
  assign next_tx_st = tx_take ? spfc_pkg::SPFC_TX_SEND :
                      tx_last ? spfc_pkg::SPFC_TX_IDLE : tx_st;

  // transmit shifter, lsb first, mark fill
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st <= spfc_pkg::SPFC_TX_IDLE;
      tx_sh <= 10'h3FF;
      tx_sub <= 4'h0;
      tx_idx <= 4'h0;
      txd <= 1'b1;
    end
    else
    begin
      tx_st <= next_tx_st;
      if (tx_take)
      begin
        tx_sh <= tx_frame;
        tx_sub <= 4'h0;
        tx_idx <= 4'h0;
        txd <= 1'b0;
      end
      else if (!tx_idle && tick)
      begin
        tx_sub <= tx_sub + 4'h1;
        if (tx_bit_end)
        begin
          tx_sh <= {1'b1, tx_sh[9:1]};
          tx_idx <= tx_idx + 4'h1;
          txd <= tx_sh[1];
        end
      end
    end
  end

  // receive character checks
  wire rx_done = (rx_st == spfc_pkg::SPFC_RX_STOP) && tick && (rx_sub == 4'hF);
  wire par_bad = seven && (rx_sh[7] != spfc_par7(rx_sh[6:0], odd));
  wire [7:0] rx_char = seven ? {1'b0, rx_sh[6:0]} : rx_sh;
  wire rx_good = rx_done && rxd && !par_bad;
  wire is_xoff = m_xon && rx_good && (rx_char == `SPFC_XOFF);
  wire is_xon = m_xon && rx_good && (rx_char == `SPFC_XON);
  wire rx_push = rx_good && !is_xoff && !is_xon;

  // receive engine, mid-bit sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st <= spfc_pkg::SPFC_RX_IDLE;
      rx_sub <= 4'h0;
      rx_idx <= 3'h0;
      rx_sh <= 8'h00;
    end
    else if (tick)
    begin
      rx_sub <= rx_sub + 4'h1;
      case (rx_st)
        spfc_pkg::SPFC_RX_IDLE:
        begin
          rx_sub <= 4'h0;
          if (!rxd)
            rx_st <= spfc_pkg::SPFC_RX_START;
        end
        spfc_pkg::SPFC_RX_START:
        begin
          if (rx_sub == 4'h7)
          begin
            rx_sub <= 4'h0;
            rx_idx <= 3'h0;
            rx_st <= rxd ? spfc_pkg::SPFC_RX_IDLE : spfc_pkg::SPFC_RX_DATA;
          end
        end
        spfc_pkg::SPFC_RX_DATA:
        begin
          if (rx_sub == 4'hF)
          begin
            rx_sh <= {rxd, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == 3'h7)
              rx_st <= spfc_pkg::SPFC_RX_STOP;
          end
        end
        spfc_pkg::SPFC_RX_STOP:
        begin
          if (rx_sub == 4'hF)
            rx_st <= spfc_pkg::SPFC_RX_IDLE;
        end
        default: rx_st <= spfc_pkg::SPFC_RX_IDLE;
      endcase
    end
  end

  // sticky errors, a new event beats a clear
  wire clr_perr = wr_stat && pwdata[`SPFC_B_PERR];
  wire clr_ferr = wr_stat && pwdata[`SPFC_B_FERR];
  wire clr_ovr = wr_stat && pwdata[`SPFC_B_OVR];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      perr <= 1'b0;
      ferr <= 1'b0;
      ovr <= 1'b0;
    end
    else
    begin
      perr <= (rx_done && rxd && par_bad) || (perr && !clr_perr);
      ferr <= (rx_done && !rxd) || (ferr && !clr_ferr);
      ovr <= (rx_push && !rxf_iready) || (ovr && !clr_ovr);
    end
  end

  // in-band halt state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_halt <= 1'b0;
    else if (!m_xon)
      tx_halt <= 1'b0;
    else if (is_xoff)
      tx_halt <= 1'b1;
    else if (is_xon)
      tx_halt <= 1'b0;
  end

  // handshake outputs, rts and dtr/dsr-mode dtr throttled by receive level, modem-mode dtr follows interface select
  wire rx_room = rxf_level < `SPFC_RX_HIGH;
  wire next_dtr = m_dtr ? rx_room : (m_modem && ctrl[`SPFC_B_IFSEL]);
  wire next_rts = (m_rts || m_modem) && rx_room;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dtr <= 1'b0;
      rts <= 1'b0;
    end
    else
    begin
      dtr <= next_dtr;
      rts <= next_rts;
    end
  end

  // transmit buffer
  spfc_fifo #(.W(8), .D(16), .AW(4)) u_txf (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(wr_tx),
    .in_ready(txf_iready),
    .in_data(pwdata[7:0]),
    .out_valid(txf_ovalid),
    .out_ready(tx_idle && tx_allow),
    .out_data(txf_odata),
    .level()
  );

  // receive buffer
  spfc_fifo #(.W(8), .D(128), .AW(7)) u_rxf (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(rx_push),
    .in_ready(rxf_iready),
    .in_data(rx_char),
    .out_valid(rxf_ovalid),
    .out_ready(rd_rx),
    .out_data(rxf_odata),
    .level(rxf_level)
  );

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_NONE_QUIET: assert property (m_none ##1 m_none |-> !dtr && !rts && !tx_halt)
    else $error("handshake active with no flow control");
  AST_XOFF_STOP: assert property (is_xoff |=> tx_halt && !tx_take)
    else $error("xoff did not halt transmission");
  AST_XON_RESUME: assert property (is_xon ##1 m_xon |-> !tx_halt)
    else $error("xon did not resume transmission");
  AST_DSR_GATE: assert property (m_dtr && tx_take |-> dsr)
    else $error("character started without dsr");
  AST_DTR_FULL: assert property (m_dtr && !rx_room |=> !dtr || $changed(ctrl))
    else $error("dtr held true with full buffer");
  AST_RTS_FULL: assert property ((m_rts || m_modem) && !rx_room |=> !rts || $changed(ctrl))
    else $error("rts held true with full buffer");
  AST_MODEM_RTS: assert property (m_modem && rx_room |=> rts || $changed(ctrl))
    else $error("rts false with room in modem mode");
  AST_MODEM_DTR: assert property (m_modem && ctrl[`SPFC_B_IFSEL] |=> dtr || $changed(ctrl))
    else $error("dtr false with serial interface selected");
  AST_CTS_GATE: assert property ((m_rts || m_modem) && tx_take |-> cts)
    else $error("character started without cts");
  AST_START_BIT: assert property (tx_take |=> (!txd)[*8])
    else $error("start bit too short");
  AST_STOP_MARK: assert property (tx_last |-> txd ##1 (txd && tx_idle))
    else $error("line not at mark after stop bit");
  AST_PARITY: assert property (tx_take && seven |=> (tx_sh[8] ^ (^tx_sh[7:1])) == $past(odd))
    else $error("wrong parity bit loaded");

  COV_XOFF_XON: cover property (is_xoff ##[1:1000] is_xon);
  COV_DSR_STALL: cover property (m_dtr && txf_ovalid && tx_idle && !dsr);
  COV_RX_THROTTLE: cover property (m_rts && $fell(rts));
  COV_ODD_FRAME: cover property (odd && tx_last);
endmodule : spfc_uart
